// ===== src/pld_pkg.sv
package pld_pkg;

    // -----------------------------------------------------------------
    // Widths
    // -----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DIFF_W = 16;
    localparam int CNT_W = 8;
    localparam int INT_W = 2;

    // -----------------------------------------------------------------
    // Register map and fields
    // -----------------------------------------------------------------
    localparam logic [7:0] ADDR_BACKLASH = 8'h10;
    localparam logic [7:0] ADDR_LOCK_CTRL = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h20;
    localparam logic [7:0] ADDR_INT_MASK = 8'h24;
    localparam logic [7:0] LOCK_CTRL_RESET = 8'h06;
    localparam logic [7:0] LOCK_CTRL_MASK = 8'hFE;
    localparam logic [1:0] BACKLASH_RESET = 2'h0;
    localparam int LC_DC_OFFSET_BIT = 7;
    localparam int LC_COUNT_LSB = 5;
    localparam int LC_WINDOW_BIT = 4;
    localparam int LC_DISABLE_BIT = 3;
    localparam int LC_CALDIV_LSB = 1;
    localparam int INT_LOCKED_BIT = 0;
    localparam int INT_LOST_BIT = 1;

    // -----------------------------------------------------------------
    // Times in picoseconds, cycle counts and divider ratios
    // -----------------------------------------------------------------
    localparam logic [15:0] ABL_2P9_PS = 16'h0B54;
    localparam logic [15:0] ABL_1P3_PS = 16'h0514;
    localparam logic [15:0] ABL_6P0_PS = 16'h1770;
    localparam logic [15:0] WINDOW_HIGH_PS = 16'h0DAC;
    localparam logic [15:0] WINDOW_LOW_DEF_PS = 16'h05DC;
    localparam logic [15:0] LOSS_HIGH_DEF_PS = 16'h1B58;
    localparam logic [15:0] LOSS_LOW_DEF_PS = 16'h0BB8;
    localparam logic [7:0] LOCK_CYC_5 = 8'h05;
    localparam logic [7:0] LOCK_CYC_16 = 8'h10;
    localparam logic [7:0] LOCK_CYC_64 = 8'h40;
    localparam logic [7:0] LOCK_CYC_255 = 8'hFF;
    localparam logic [4:0] CAL_DIV_2 = 5'h02;
    localparam logic [4:0] CAL_DIV_4 = 5'h04;
    localparam logic [4:0] CAL_DIV_8 = 5'h08;
    localparam logic [4:0] CAL_DIV_16 = 5'h10;

    // Maps the antibacklash code to its pulse width.
    function automatic logic [15:0] abl_width_of(input logic [1:0] code);
        case (code)
            2'h1: return ABL_1P3_PS;
            2'h2: return ABL_6P0_PS;
            2'h0, 2'h3: return ABL_2P9_PS;
        endcase
        return ABL_2P9_PS;
    endfunction

    // Maps the run length code to the required in-window cycles.
    function automatic logic [7:0] lock_cycles_of(input logic [1:0] code);
        case (code)
            2'h0: return LOCK_CYC_5;
            2'h1: return LOCK_CYC_16;
            2'h2: return LOCK_CYC_64;
            2'h3: return LOCK_CYC_255;
        endcase
        return LOCK_CYC_5;
    endfunction

    // Maps the calibration divider code to its ratio.
    function automatic logic [4:0] cal_ratio_of(input logic [1:0] code);
        case (code)
            2'h0: return CAL_DIV_2;
            2'h1: return CAL_DIV_4;
            2'h2: return CAL_DIV_8;
            2'h3: return CAL_DIV_16;
        endcase
        return CAL_DIV_16;
    endfunction

endpackage

// ===== src/pld_cal_divider.sv
`timescale 1ns/1ps
`default_nettype none
module pld_cal_divider (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic ref_tick, // One pulse per reference clock period.
    input wire logic [1:0] div_code, // Divider selection code.
    output logic cal_tick // One pulse per divided period.
);
    import pld_pkg::*;

    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic tick_reg;
    logic tick_next;
    logic [4:0] ratio;

    // Counts reference ticks and wraps at the chosen ratio.
    always_comb begin
        ratio = cal_ratio_of(div_code);
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (ref_tick) begin
            if (cnt_reg >= ratio - 5'h01) begin
                cnt_next = 5'h00;
                tick_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + 5'h01;
            end
        end
    end

    // Registers the divider state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 5'h00;
            tick_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign cal_tick = tick_reg;

    // Helper that counts ticks between outputs and notes code changes.
    logic [4:0] seen_reg;
    logic dirty_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_reg <= 5'h00;
            dirty_reg <= 1'b0;
        end else begin
            seen_reg <= (tick_reg ? 5'h00 : seen_reg) + {4'h0, ref_tick};
            dirty_reg <= (tick_reg ? 1'b0 : dirty_reg) | (div_code != $past(div_code));
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_CAL_PERIOD: assert property (cal_tick && !dirty_reg |-> seen_reg == ratio)
        else $error("Calibration tick period does not match the divider code.");
    AST_CAL_FROM_REF: assert property (cal_tick |-> $past(ref_tick))
        else $error("Calibration tick without a reference tick.");
endmodule
`default_nettype wire

// ===== src/pld_lock_counter.sv
`timescale 1ns/1ps
`default_nettype none
module pld_lock_counter (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic pfd_strobe, // One pulse per comparison cycle.
    input wire logic in_window, // Edge gap below the lock window.
    input wire logic beyond_loss, // Edge gap above the loss threshold.
    input wire logic lock_disable, // Lock detection switched off.
    input wire logic [pld_pkg::CNT_W-1:0] need_cycles, // Required run length.
    output logic lock_flag, // Digital lock flag.
    output logic locked_evt, // Pulse when lock is gained.
    output logic lost_evt // Pulse when lock is lost.
);
    import pld_pkg::*;

    typedef enum logic {LK_HUNT, LK_LOCKED} pld_lock_state_type;

    pld_lock_state_type state_reg;
    pld_lock_state_type state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic flag_reg;
    logic flag_next;
    logic lck_reg;
    logic lck_next;
    logic lst_reg;
    logic lst_next;

    // Tracks the consecutive in-window run and the lock state.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        lck_next = 1'b0;
        lst_next = 1'b0;
        if (lock_disable) begin
            state_next = LK_HUNT;
            cnt_next = '0;
            lst_next = (state_reg == LK_LOCKED);
        end else if (pfd_strobe) begin
            unique case (state_reg)
                LK_HUNT: begin
                    if (in_window) begin
                        if (cnt_reg >= need_cycles - 8'h01) begin
                            state_next = LK_LOCKED;
                            cnt_next = '0;
                            lck_next = 1'b1;
                        end else begin
                            cnt_next = cnt_reg + 8'h01;
                        end
                    end else begin
                        cnt_next = '0;
                    end
                end
                LK_LOCKED: begin
                    if (beyond_loss) begin
                        state_next = LK_HUNT;
                        lst_next = 1'b1;
                    end
                    cnt_next = '0;
                end
            endcase
        end
        flag_next = (state_next == LK_LOCKED);
    end

    // Registers the lock state and its event pulses.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= LK_HUNT;
            cnt_reg <= '0;
            flag_reg <= 1'b0;
            lck_reg <= 1'b0;
            lst_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            flag_reg <= flag_next;
            lck_reg <= lck_next;
            lst_reg <= lst_next;
        end
    end

    assign lock_flag = flag_reg;
    assign locked_evt = lck_reg;
    assign lost_evt = lst_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_last_hit;
        pfd_strobe && in_window && !lock_disable && state_reg == LK_HUNT &&
            cnt_reg == need_cycles - 8'h01;
    endsequence

    sequence s_miss;
        pfd_strobe && !in_window && !lock_disable && state_reg == LK_HUNT;
    endsequence

    AST_ACQUIRE: assert property (s_last_hit |=> lock_flag ##0 locked_evt)
        else $error("Lock not set after the final in-window cycle.");
    AST_NO_EARLY: assert property ($rose(lock_flag) |->
            $past(cnt_reg) >= $past(need_cycles) - 8'h01)
        else $error("Lock set before the run was complete.");
    AST_RUN_BREAK: assert property (s_miss |=> cnt_reg == '0 && !lock_flag)
        else $error("Run counter kept counting after a miss.");
    AST_HOLD: assert property (lock_flag && !lock_disable && !(pfd_strobe && beyond_loss)
            |=> lock_flag)
        else $error("Lock dropped without a gap over the loss threshold.");
    AST_DISABLE: assert property (lock_disable |=> !lock_flag)
        else $error("Lock flag set while detection is disabled.");
endmodule
`default_nettype wire

// ===== src/pld_top.sv
`timescale 1ns/1ps
`default_nettype none
module pld_top #(
    parameter logic [15:0] WINDOW_LOW_PS = pld_pkg::WINDOW_LOW_DEF_PS, // Low range window.
    parameter logic [15:0] LOSS_HIGH_PS = pld_pkg::LOSS_HIGH_DEF_PS, // High range loss gap.
    parameter logic [15:0] LOSS_LOW_PS = pld_pkg::LOSS_LOW_DEF_PS // Low range loss gap.
) (
    input wire logic pclk, // System clock, 20 MHz.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction, high for write.
    input wire logic [pld_pkg::ADDR_W-1:0] paddr, // APB byte address.
    input wire logic [pld_pkg::DATA_W-1:0] pwdata, // APB write data.
    output logic [pld_pkg::DATA_W-1:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic pfd_strobe, // One pulse per comparison cycle.
    input wire logic [pld_pkg::DIFF_W-1:0] pfd_diff_ps, // Edge gap in ps.
    input wire logic ref_tick, // One pulse per reference period.
    output logic digital_lock_flag, // Digital lock indication.
    output logic ref_dc_offset_en, // Reference dc offset enable.
    output logic [15:0] abl_width_ps, // Antibacklash pulse width in ps.
    output logic cal_tick, // Calibration clock enable pulse.
    output logic irq // Level interrupt, active high.
);
    import pld_pkg::*;

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic [1:0] backlash_reg;
    logic [1:0] backlash_next;
    logic [7:0] lock_ctrl_reg;
    logic [7:0] lock_ctrl_next;
    logic [INT_W-1:0] int_status_reg;
    logic [INT_W-1:0] int_status_next;
    logic [INT_W-1:0] int_mask_reg;
    logic [INT_W-1:0] int_mask_next;
    logic irq_reg;
    logic irq_next;
    logic [15:0] abl_reg;
    logic [15:0] abl_next;
    logic dc_reg;
    logic dc_next;
    logic setup_phase;
    logic wr_en;
    logic [15:0] window_ps;
    logic [15:0] loss_ps;
    logic in_window;
    logic beyond_loss;
    logic locked_evt;
    logic lost_evt;
    logic lock_flag;
    logic cal_tick_int;

    // True when the address selects a mapped, aligned register.
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        return (addr == ADDR_BACKLASH) || (addr == ADDR_LOCK_CTRL) ||
            (addr == ADDR_STATUS) || (addr == ADDR_INT_STATUS) ||
            (addr == ADDR_INT_MASK);
    endfunction

    // -----------------------------------------------------------------
    // APB slave
    // -----------------------------------------------------------------

    // Setup is detected here; every transfer completes with no wait state.
    assign setup_phase = psel && !penable;
    assign wr_en = psel && penable && pready_reg && pwrite && is_mapped(paddr);

    // Computes the answer of the access phase from the setup cycle.
    always_comb begin
        pready_next = setup_phase;
        pslverr_next = setup_phase && !is_mapped(paddr);
        prdata_next = prdata_reg;
        if (setup_phase && !pwrite) begin
            prdata_next = 32'h0000_0000;
            case (paddr)
                ADDR_BACKLASH: prdata_next = {30'h0000_0000, backlash_reg};
                ADDR_LOCK_CTRL: prdata_next = {24'h00_0000, lock_ctrl_reg};
                ADDR_STATUS: prdata_next = {31'h0000_0000, lock_flag};
                ADDR_INT_STATUS: prdata_next = {30'h0000_0000, int_status_reg};
                ADDR_INT_MASK: prdata_next = {30'h0000_0000, int_mask_reg};
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Registers the bus answer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------

    // Takes software writes; the calibration start bit is not kept here.
    always_comb begin
        backlash_next = backlash_reg;
        lock_ctrl_next = lock_ctrl_reg;
        if (wr_en && paddr == ADDR_BACKLASH) begin
            backlash_next = pwdata[1:0];
        end
        if (wr_en && paddr == ADDR_LOCK_CTRL) begin
            lock_ctrl_next = pwdata[7:0] & LOCK_CTRL_MASK;
        end
    end

    // Registers the configuration.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            backlash_reg <= BACKLASH_RESET;
            lock_ctrl_reg <= LOCK_CTRL_RESET;
        end else begin
            backlash_reg <= backlash_next;
            lock_ctrl_reg <= lock_ctrl_next;
        end
    end

    // Drives the analog controls from the configuration.
    always_comb begin
        abl_next = abl_width_of(backlash_reg);
        dc_next = lock_ctrl_reg[LC_DC_OFFSET_BIT];
    end

    // Registers the analog controls so the outputs come from flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abl_reg <= ABL_2P9_PS;
            dc_reg <= 1'b0;
        end else begin
            abl_reg <= abl_next;
            dc_reg <= dc_next;
        end
    end

    assign abl_width_ps = abl_reg;
    assign ref_dc_offset_en = dc_reg;

    // -----------------------------------------------------------------
    // Lock window comparison
    // -----------------------------------------------------------------

    // Selects window and loss threshold by range and compares the gap.
    always_comb begin
        window_ps = lock_ctrl_reg[LC_WINDOW_BIT] ? WINDOW_LOW_PS : WINDOW_HIGH_PS;
        loss_ps = lock_ctrl_reg[LC_WINDOW_BIT] ? LOSS_LOW_PS : LOSS_HIGH_PS;
        in_window = pfd_diff_ps < window_ps;
        beyond_loss = pfd_diff_ps > loss_ps;
    end

    // Counts the in-window run and holds the lock flag.
    pld_lock_counter u_lock (
        .pclk(pclk),
        .presetn(presetn),
        .pfd_strobe(pfd_strobe),
        .in_window(in_window),
        .beyond_loss(beyond_loss),
        .lock_disable(lock_ctrl_reg[LC_DISABLE_BIT]),
        .need_cycles(lock_cycles_of(lock_ctrl_reg[LC_COUNT_LSB +: 2])),
        .lock_flag(lock_flag),
        .locked_evt(locked_evt),
        .lost_evt(lost_evt)
    );

    assign digital_lock_flag = lock_flag;

    // Divides reference ticks into the calibration clock enable.
    pld_cal_divider u_cal (
        .pclk(pclk),
        .presetn(presetn),
        .ref_tick(ref_tick),
        .div_code(lock_ctrl_reg[LC_CALDIV_LSB +: 2]),
        .cal_tick(cal_tick_int)
    );

    assign cal_tick = cal_tick_int;

    // -----------------------------------------------------------------
    // Interrupts
    // -----------------------------------------------------------------

    // Sets sticky bits on lock events; a new event beats a write of one.
    always_comb begin
        int_status_next = int_status_reg;
        int_mask_next = int_mask_reg;
        if (wr_en && paddr == ADDR_INT_STATUS) begin
            int_status_next = int_status_reg & ~pwdata[INT_W-1:0];
        end
        if (wr_en && paddr == ADDR_INT_MASK) begin
            int_mask_next = pwdata[INT_W-1:0];
        end
        int_status_next[INT_LOCKED_BIT] = int_status_next[INT_LOCKED_BIT] | locked_evt;
        int_status_next[INT_LOST_BIT] = int_status_next[INT_LOST_BIT] | lost_evt;
        irq_next = |(int_status_next & int_mask_next);
    end

    // Registers status, mask and the interrupt line.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status_reg <= '0;
            int_mask_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            int_status_reg <= int_status_next;
            int_mask_reg <= int_mask_next;
            irq_reg <= irq_next;
        end
    end

    assign irq = irq_reg;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_write_ctrl;
        wr_en && paddr == ADDR_LOCK_CTRL;
    endsequence

    AST_ABL_SHORT: assert property (backlash_reg == 2'h1 |=> abl_width_ps == 16'h0514)
        else $error("Code 01 does not give 1.3 ns.");
    AST_ABL_LONG: assert property (backlash_reg == 2'h2 |=> abl_width_ps == 16'h1770)
        else $error("Code 10 does not give 6.0 ns.");
    AST_DC_OFFSET: assert property (s_write_ctrl |=> ##1 ref_dc_offset_en == $past(pwdata[7], 2))
        else $error("Dc offset enable does not follow bit 7.");
    AST_WINDOW_HIGH: assert property (!lock_ctrl_reg[LC_WINDOW_BIT] |->
            in_window == (pfd_diff_ps < 16'h0DAC))
        else $error("High range window is not 3.5 ns.");
    AST_APB_ANSWER: assert property (setup_phase |=> pready ##1 !pready)
        else $error("Access phase not answered in one cycle.");
    AST_IRQ_LEVEL: assert property (|(int_status_reg & int_mask_reg) |-> ##[0:1] irq)
        else $error("Unmasked status bit does not raise the interrupt.");
    AST_SET_WINS: assert property (locked_evt |=> int_status_reg[INT_LOCKED_BIT])
        else $error("Lock event lost against a clear.");
endmodule
`default_nettype wire

// ===== tb/pld_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module pld_top_tb;
    import pld_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pfd_strobe, ref_tick;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, digital_lock_flag, ref_dc_offset_en, cal_tick, irq;
    logic [15:0] pfd_diff_ps, abl_width_ps;
    int failures = 0;
    int checks = 0;
    int ticks = 0;
    // Rows: backlash code, expected width, run code, expected run length.
    logic [1:0] row_code [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    logic [15:0] row_abl [4] = '{16'h0B54, 16'h0514, 16'h1770, 16'h0B54};
    int row_run [4] = '{5, 16, 64, 255};

    pld_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pfd_strobe(pfd_strobe), .pfd_diff_ps(pfd_diff_ps),
        .ref_tick(ref_tick), .digital_lock_flag(digital_lock_flag),
        .ref_dc_offset_en(ref_dc_offset_en), .abl_width_ps(abl_width_ps),
        .cal_tick(cal_tick), .irq(irq));

    // Clock at 20 MHz.
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // One APB transfer; waits for pready under a bounded count.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Sends n back-to-back comparison strobes, then lets the flag settle.
    task automatic lk(input logic [15:0] diff, input int n);
        repeat (n) begin
            pfd_strobe <= 1'b1; pfd_diff_ps <= diff;
            @(posedge pclk);
        end
        pfd_strobe <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Watchdog cuts a hang short.
    initial begin
        repeat (30000) @(posedge pclk);
        failures++;
        end_sim();
    end

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0000_0000; pfd_strobe = 1'b0; pfd_diff_ps = 16'h0000; ref_tick = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        `CHK(abl_width_ps, 16'h0B54) // default width
        `CHK(ref_dc_offset_en, 1'b0) // default off
        apb(1'b0, 8'h18, 32'h0); `CHK(rd, 32'h0000_0006) // default divider
        apb(1'b1, 8'h24, 32'h0000_0001);
        // Table rows: width per code, run length per code.
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h10, {30'h0, row_code[i]});
            repeat (2) @(posedge pclk);
            `CHK(abl_width_ps, row_abl[i]) // width code
            apb(1'b1, 8'h18, {25'h0, row_code[i], 5'h06});
            lk(16'h03E8, row_run[i] - 1); `CHK(digital_lock_flag, 1'b0) // short run
            lk(16'h0FA0, 1); lk(16'h03E8, row_run[i] - 1);
            `CHK(digital_lock_flag, 1'b0) // run restarts
            lk(16'h03E8, 1); `CHK(digital_lock_flag, 1'b1) // run length
            `CHK(irq, 1'b1) // lock event raises irq
            apb(1'b0, 8'h1C, 32'h0); `CHK(rd[0], 1'b1) // status flag
            lk(16'h1388, 2); `CHK(digital_lock_flag, 1'b1) // hysteresis holds
            lk(16'h1F40, 1); `CHK(digital_lock_flag, 1'b0) // loss clears
            apb(1'b1, 8'h20, 32'h0000_0003);
            repeat (2) @(posedge pclk);
            `CHK(irq, 1'b0) // write one clears
        end
        // Low window range: a 2000 ps gap no longer counts.
        apb(1'b1, 8'h18, 32'h0000_0016);
        lk(16'h07D0, 5); `CHK(digital_lock_flag, 1'b0) // low range
        lk(16'h03E8, 5); `CHK(digital_lock_flag, 1'b1) // low range
        // Disable while locked, then no lock can form.
        apb(1'b1, 8'h18, 32'h0000_001E);
        repeat (2) @(posedge pclk);
        `CHK(digital_lock_flag, 1'b0) // disable clears
        lk(16'h03E8, 8); `CHK(digital_lock_flag, 1'b0) // stays off
        // Masked interrupt stays low.
        apb(1'b1, 8'h20, 32'h0000_0003);
        apb(1'b1, 8'h24, 32'h0000_0000);
        apb(1'b1, 8'h18, 32'h0000_0006);
        lk(16'h03E8, 5); `CHK(irq, 1'b0) // masked event
        apb(1'b0, 8'h20, 32'h0); `CHK(rd[0], 1'b1) // sticky status
        // Offset enable and readback.
        apb(1'b1, 8'h18, 32'h0000_0086);
        apb(1'b0, 8'h18, 32'h0); `CHK(rd, 32'h0000_0086) // readback
        `CHK(ref_dc_offset_en, 1'b1) // offset on
        apb(1'b0, 8'h18, 32'h0000_0002); `CHK(rd[2:1], 2'h3) // divider field
        // Divide-by-16: 32 back-to-back reference ticks give two calibration ticks.
        repeat (32) begin
            ref_tick <= 1'b1;
            @(posedge pclk);
            ticks += int'(cal_tick);
        end
        ref_tick <= 1'b0;
        repeat (3) begin
            @(posedge pclk);
            ticks += int'(cal_tick);
        end
        `CHK(ticks, 2) // divide by sixteen
        // Unmapped address is refused.
        apb(1'b0, 8'h40, 32'h0); `CHK(err, 1'b1) // unmapped read
        end_sim();
    end
endmodule
`default_nettype wire
